// >>> logic/mmbd_top.sv
// Memory map and bank decoder for a small 8-bit controller.
// Assumes the core drives a direct data port and a fetch-control port,
// one clock, and never raises both data strobes in the same cycle.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module mmbd_top #(
  parameter int PC_W   = mmbd_pkg::PC_W,
  parameter int IMPL_W = mmbd_pkg::PROG_IMPL_W,
  parameter int DEPTH  = mmbd_pkg::GPR_DEPTH
) (
  input  wire logic              CLK,
  input  wire logic              RESET_N,
  input  wire logic              CE,
  // Fetch control from the core
  input  wire logic              PC_STEP,
  input  wire logic              PC_IRQ,
  input  wire logic              PC_LOAD,
  input  wire logic [PC_W-1:0]   PC_LOAD_ADDR,
  output logic      [PC_W-1:0]   PC_VALUE,
  output logic      [IMPL_W-1:0] PROG_ADDR,
  // Data access from the core
  input  wire logic [6:0]        DATA_ADDR,
  input  wire logic [7:0]        DATA_WDATA,
  input  wire logic              DATA_WR,
  input  wire logic              DATA_RD,
  output logic      [7:0]        DATA_RDATA,
  // Core register state for the rest of the device
  output logic                   BANK_SEL,
  output logic      [7:0]        STATUS_VALUE,
  output logic      [7:0]        INTERRUPT_CONTROL_VALUE,
  output logic      [4:0]        PROGRAM_COUNTER_HIGH_LATCH_VALUE
);

  // ==========================================================
  // Core register storage
  // Only the core registers live here; peripheral slots read zero
  logic [7:0]                 status_q;
  logic [7:0]                 ptr_q;
  logic [mmbd_pkg::PROGRAM_COUNTER_HIGH_LATCH_W-1:0] program_counter_high_latch_q;
  logic [7:0]                 interrupt_control_q;
  logic [7:0]                 rdata_q;

  logic [PC_W-1:0]            pc_q;
  logic [IMPL_W-1:0]          fetch_q;

  // ==========================================================
  // Address resolution
  logic [7:0]                 eff_addr;
  logic [6:0]                 eff_lo;
  logic                       via_ptr;
  mmbd_pkg::mmbd_region_t     region;
  logic [mmbd_pkg::GPR_AW-1:0] gpr_idx;
  logic [7:0]                 gpr_rdata;
  logic [7:0]                 rdata_d;

  logic                       wr_pcl;
  logic                       wr_status;
  logic                       wr_ptr;
  logic                       wr_program_counter_high_latch;
  logic                       wr_interrupt_control;
  logic                       wr_gpr;
  logic                       pc_load;
  logic [PC_W-1:0]            pc_load_addr;

  // Classify an 8-bit data address (bank bit on top)
  function automatic mmbd_pkg::mmbd_region_t decode(
    input logic [7:0] a
  );
    logic [6:0] lo;
    logic       bank;
    lo     = a[6:0];
    bank   = a[7];
    decode = mmbd_pkg::RG_NONE;
    if (lo <= mmbd_pkg::SFR_LAST) begin
      // Same core offsets in either bank
      unique case (lo)
        mmbd_pkg::OFS_PCL:    decode = mmbd_pkg::RG_PCL;
        mmbd_pkg::OFS_STATUS: decode = mmbd_pkg::RG_STATUS;
        mmbd_pkg::OFS_PTR:    decode = mmbd_pkg::RG_PTR;
        mmbd_pkg::OFS_PROGRAM_COUNTER_HIGH_LATCH: decode = mmbd_pkg::RG_PROGRAM_COUNTER_HIGH_LATCH;
        mmbd_pkg::OFS_INTERRUPT_CONTROL: decode = mmbd_pkg::RG_INTERRUPT_CONTROL;
        default:              decode = mmbd_pkg::RG_NONE;
      endcase
    end else if (!bank && lo >= mmbd_pkg::GPR_FIRST
                 && lo <= mmbd_pkg::GPR_LAST) begin
      decode = mmbd_pkg::RG_GPR;
    end else if (bank && lo >= mmbd_pkg::MIRROR_FIRST) begin
      decode = mmbd_pkg::RG_GPR;
    end
  endfunction

  // Direct uses the bank bit; location 0 of a bank uses the pointer.
  // The reserved indirect bank bit is not used: two banks only.
  // Pointer bit 7 picks the bank, so one pointer reaches both banks.
  assign via_ptr  = (DATA_ADDR == mmbd_pkg::OFS_INDIRECT);
  assign eff_addr = via_ptr ? ptr_q
                            : {status_q[mmbd_pkg::ST_RP0],
                               DATA_ADDR};

  // Offset within whichever bank the access resolved to
  assign eff_lo = eff_addr[mmbd_pkg::DIR_AW-1:0];

  // A pointer aimed at the window itself reaches nothing; this also
  // stops an indirect access from recursing through the window
  always_comb begin
    if (eff_lo == mmbd_pkg::OFS_INDIRECT) begin
      region = mmbd_pkg::RG_NONE;
    end else begin
      region = decode(eff_addr);
    end
  end

  // 70h-7Fh and F0h-FFh share their low six bits, so one index
  // serves both views of the same byte
  assign gpr_idx = eff_addr[mmbd_pkg::GPR_AW-1:0];

  // ==========================================================
  // Write strobes per target
  // One decoded target per cycle, so at most one strobe is high
  always_comb begin
    wr_pcl    = 1'b0;
    wr_status = 1'b0;
    wr_ptr    = 1'b0;
    wr_program_counter_high_latch = 1'b0;
    wr_interrupt_control = 1'b0;
    wr_gpr    = 1'b0;
    if (DATA_WR) begin
      unique case (region)
        mmbd_pkg::RG_PCL:    wr_pcl    = 1'b1;
        mmbd_pkg::RG_STATUS: wr_status = 1'b1;
        mmbd_pkg::RG_PTR:    wr_ptr    = 1'b1;
        mmbd_pkg::RG_PROGRAM_COUNTER_HIGH_LATCH: wr_program_counter_high_latch = 1'b1;
        mmbd_pkg::RG_INTERRUPT_CONTROL: wr_interrupt_control = 1'b1;
        mmbd_pkg::RG_GPR:    wr_gpr    = 1'b1;
        // Unimplemented targets raise no strobe: the write is dropped
        default:             wr_gpr    = 1'b0;
      endcase
    end
  end

  // A write to the low byte jumps with the latched upper bits;
  // a core jump in the same cycle takes precedence
  assign pc_load      = PC_LOAD || wr_pcl;
  assign pc_load_addr = PC_LOAD ? PC_LOAD_ADDR
                                : {program_counter_high_latch_q, DATA_WDATA};

  // ==========================================================
  // Program counter
  // The interrupt vector outranks both kinds of jump inside the
  // counter, so a vector is never lost to a jump
  mmbd_prog_ctr #(
    .PC_W      (PC_W),
    .IMPL_W    (IMPL_W)
  ) u_pc (
    .clk       (CLK),
    .reset_n   (RESET_N),
    .ce        (CE),
    .irq       (PC_IRQ),
    .load      (pc_load),
    .load_addr (pc_load_addr),
    .step      (PC_STEP),
    .pc_q      (pc_q),
    .fetch_q   (fetch_q)
  );

  // ==========================================================
  // General-purpose storage
  // Same index for read and write; the two strobes never meet
  mmbd_gpr_ram #(
    .DEPTH (DEPTH),
    .AW    (mmbd_pkg::GPR_AW),
    .W     (mmbd_pkg::DATA_W)
  ) u_gpr (
    .clk   (CLK),
    .ce    (CE),
    .we    (wr_gpr),
    .waddr (gpr_idx),
    .wdata (DATA_WDATA),
    .raddr (gpr_idx),
    .rdata (gpr_rdata)
  );

  // ==========================================================
  // Status: timeout and power-down flags are read-only here.
  // Reserved bank bits are stored as written; software keeps them 0.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      status_q <= mmbd_pkg::STATUS_RST;
    end else if (CE && wr_status) begin
      status_q[mmbd_pkg::ST_IRP] <= DATA_WDATA[mmbd_pkg::ST_IRP];
      status_q[mmbd_pkg::ST_RP1] <= DATA_WDATA[mmbd_pkg::ST_RP1];
      status_q[mmbd_pkg::ST_RP0] <= DATA_WDATA[mmbd_pkg::ST_RP0];
      status_q[mmbd_pkg::ST_PD-1:0] <=
        DATA_WDATA[mmbd_pkg::ST_PD-1:0];
    end
  end

  // ==========================================================
  // Pointer
  // Any value is legal; 00h and 80h reach nothing
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ptr_q <= mmbd_pkg::PTR_RST;
    end else if (CE && wr_ptr) begin
      ptr_q <= DATA_WDATA;
    end
  end

  // ==========================================================
  // Upper program counter latch
  // Five bits kept; the top three read back as zero
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      program_counter_high_latch_q <= mmbd_pkg::PROGRAM_COUNTER_HIGH_LATCH_RST;
    end else if (CE && wr_program_counter_high_latch) begin
      program_counter_high_latch_q <= DATA_WDATA[mmbd_pkg::PROGRAM_COUNTER_HIGH_LATCH_W-1:0];
    end
  end

  // ==========================================================
  // Interrupt control, plain storage for the core
  // Nothing sets flags here, so no set-versus-clear race arises
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      interrupt_control_q <= mmbd_pkg::INTERRUPT_CONTROL_RST;
    end else if (CE && wr_interrupt_control) begin
      interrupt_control_q <= DATA_WDATA;
    end
  end

  // ==========================================================
  // Read path: data stand one cycle after the strobe, then zero
  // Idle zero lets the core merge this bus with other read sources;
  // a low clock enable holds the last read data with everything else
  always_comb begin
    unique case (region)
      mmbd_pkg::RG_PCL:    rdata_d = pc_q[7:0];
      mmbd_pkg::RG_STATUS: rdata_d = status_q;
      mmbd_pkg::RG_PTR:    rdata_d = ptr_q;
      mmbd_pkg::RG_PROGRAM_COUNTER_HIGH_LATCH: rdata_d = {mmbd_pkg::PROGRAM_COUNTER_HIGH_LATCH_PAD, program_counter_high_latch_q};
      mmbd_pkg::RG_INTERRUPT_CONTROL: rdata_d = interrupt_control_q;
      mmbd_pkg::RG_GPR:    rdata_d = gpr_rdata;
      default:             rdata_d = mmbd_pkg::READ_ZERO;
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_q <= mmbd_pkg::READ_ZERO;
    end else if (CE) begin
      rdata_q <= DATA_RD ? rdata_d : mmbd_pkg::READ_ZERO;
    end
  end

  // ==========================================================
  // Outputs, all from flip-flops
  // Bank select is a copy of one status bit, kept as its own port
  assign PC_VALUE     = pc_q;
  assign PROG_ADDR    = fetch_q;
  assign DATA_RDATA   = rdata_q;
  assign BANK_SEL     = status_q[mmbd_pkg::ST_RP0];
  assign STATUS_VALUE = status_q;
  assign INTERRUPT_CONTROL_VALUE = interrupt_control_q;
  assign PROGRAM_COUNTER_HIGH_LATCH_VALUE = program_counter_high_latch_q;

endmodule

// >>> logic/mmbd_pkg.sv
// Constants and types for the memory map and bank decoder.
// Assumes one clock domain; shared by the top and its two leaf modules.
package mmbd_pkg;

  // ==========================================================
  // Program memory
  localparam int             PC_W         = 13;
  localparam int             PROG_IMPL_W  = 10;
  localparam logic [12:0]    RESET_VECTOR = 13'h0000;
  localparam logic [12:0]    IRQ_VECTOR   = 13'h0004;
  localparam logic [12:0]    PC_STEP      = 13'h0001;

  // ==========================================================
  // Data memory geometry
  localparam int             DATA_W       = 8;
  localparam int             DIR_AW       = 7;
  localparam int             FULL_AW      = 8;
  localparam int             GPR_DEPTH    = 64;
  localparam int             GPR_AW       = 6;
  localparam logic [6:0]     SFR_LAST     = 7'h1F;
  localparam logic [6:0]     GPR_FIRST    = 7'h40;
  localparam logic [6:0]     GPR_LAST     = 7'h7F;
  localparam logic [6:0]     MIRROR_FIRST = 7'h70;
  localparam logic [7:0]     READ_ZERO    = 8'h00;

  // ==========================================================
  // Core register offsets, identical in both banks
  localparam logic [6:0]     OFS_INDIRECT = 7'h00;
  localparam logic [6:0]     OFS_PCL      = 7'h02;
  localparam logic [6:0]     OFS_STATUS   = 7'h03;
  localparam logic [6:0]     OFS_PTR      = 7'h04;
  localparam logic [6:0]     OFS_PROGRAM_COUNTER_HIGH_LATCH   = 7'h0A;
  localparam logic [6:0]     OFS_INTERRUPT_CONTROL   = 7'h0B;

  // ==========================================================
  // Status layout and reset values
  localparam int             ST_IRP       = 7;
  localparam int             ST_RP1       = 6;
  localparam int             ST_RP0       = 5;
  localparam int             ST_TO        = 4;
  localparam int             ST_PD        = 3;
  localparam int             PROGRAM_COUNTER_HIGH_LATCH_W     = 5;
  localparam logic [7:0]     STATUS_RST   = 8'h18;
  localparam logic [7:0]     PTR_RST      = 8'h00;
  localparam logic [4:0]     PROGRAM_COUNTER_HIGH_LATCH_RST   = 5'h00;
  localparam logic [7:0]     INTERRUPT_CONTROL_RST   = 8'h00;
  localparam logic [2:0]     PROGRAM_COUNTER_HIGH_LATCH_PAD   = 3'h0;

  // ==========================================================
  // Decoded data regions
  typedef enum logic [2:0] {
    RG_NONE,
    RG_PCL,
    RG_STATUS,
    RG_PTR,
    RG_PROGRAM_COUNTER_HIGH_LATCH,
    RG_INTERRUPT_CONTROL,
    RG_GPR
  } mmbd_region_t;

endpackage

// >>> logic/mmbd_prog_ctr.sv
// Program counter with reset and interrupt vectors.
// Assumes the core gives at most one kind of request priority per cycle.
`timescale 1ns/1ps
module mmbd_prog_ctr #(
  parameter int PC_W   = mmbd_pkg::PC_W,
  parameter int IMPL_W = mmbd_pkg::PROG_IMPL_W
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              ce,
  input  wire logic              irq,
  input  wire logic              load,
  input  wire logic [PC_W-1:0]   load_addr,
  input  wire logic              step,
  output logic      [PC_W-1:0]   pc_q,
  output logic      [IMPL_W-1:0] fetch_q
);

  logic [PC_W-1:0] pc_d;

  // ==========================================================
  // Next counter value, interrupt first
  always_comb begin
    pc_d = pc_q;
    if (irq) begin
      pc_d = mmbd_pkg::IRQ_VECTOR;
    end else if (load) begin
      pc_d = load_addr;
    end else if (step) begin
      pc_d = pc_q + mmbd_pkg::PC_STEP;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_q <= mmbd_pkg::RESET_VECTOR;
    end else if (ce) begin
      pc_q <= pc_d;
    end
  end

  // Upper bits dropped: fetches above 1K fold back, never fault
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fetch_q <= mmbd_pkg::RESET_VECTOR[IMPL_W-1:0];
    end else if (ce) begin
      fetch_q <= pc_d[IMPL_W-1:0];
    end
  end

endmodule

// >>> logic/mmbd_gpr_ram.sv
// General-purpose storage array, one write port, one async read port.
// Assumes the caller registers the read data before it leaves the block.
`timescale 1ns/1ps
module mmbd_gpr_ram #(
  parameter int DEPTH = mmbd_pkg::GPR_DEPTH,
  parameter int AW    = mmbd_pkg::GPR_AW,
  parameter int W     = mmbd_pkg::DATA_W
) (
  input  wire logic          clk,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);

  // Contents are undefined after reset, as in the static RAM
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];

endmodule

// >>> verification/mmbd_top_checker.sv
// Concurrent checks on the ports of the memory map and bank decoder.
// Assumes it is bound to mmbd_top and sees one clock and reset.
`timescale 1ns/1ps
module mmbd_top_checker #(
  parameter int PC_W   = 13,
  parameter int IMPL_W = 10
) (
  input wire logic              CLK,
  input wire logic              RESET_N,
  input wire logic              CE,
  input wire logic              PC_STEP,
  input wire logic              PC_IRQ,
  input wire logic              PC_LOAD,
  input wire logic [PC_W-1:0]   PC_LOAD_ADDR,
  input wire logic [PC_W-1:0]   PC_VALUE,
  input wire logic [IMPL_W-1:0] PROG_ADDR,
  input wire logic [6:0]        DATA_ADDR,
  input wire logic [7:0]        DATA_WDATA,
  input wire logic              DATA_WR,
  input wire logic              DATA_RD,
  input wire logic [7:0]        DATA_RDATA,
  input wire logic              BANK_SEL,
  input wire logic [7:0]        STATUS_VALUE,
  input wire logic [4:0]        PROGRAM_COUNTER_HIGH_LATCH_VALUE
);
  // ==========================================================
  // Helpers
  logic [7:0] wd_q;
  always_ff @(posedge CLK) begin
    wd_q <= DATA_WDATA;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // ==========================================================
  // Properties
  property p_wrap;
    PROG_ADDR == PC_VALUE[IMPL_W-1:0];
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("fetch address not wrapped");
  property p_irq;
    CE && PC_IRQ |=> PC_VALUE == 13'h0004;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt vector wrong");
  property p_load;
    CE && PC_LOAD && !PC_IRQ |=> PC_VALUE == $past(PC_LOAD_ADDR);
  endproperty
  a_load: assert property (p_load)
    else $error("jump target lost");
  property p_step;
    CE && PC_STEP && !PC_IRQ && !PC_LOAD && !DATA_WR
      |=> PC_VALUE == $past(PC_VALUE) + 1'b1;
  endproperty
  a_step: assert property (p_step)
    else $error("step not by one");
  property p_hole;
    CE && DATA_RD && DATA_ADDR[6:5] == 2'b01 |=> DATA_RDATA == 8'h00;
  endproperty
  a_hole: assert property (p_hole)
    else $error("empty area not zero");
  property p_idle;
    CE && !DATA_RD |=> DATA_RDATA == 8'h00;
  endproperty
  a_idle: assert property (p_idle)
    else $error("read data lingers");
  // Bank 1 has nothing at C0h-EFh, so direct reads there give zero
  property p_bank;
    CE && DATA_RD && BANK_SEL && DATA_ADDR[6] && DATA_ADDR[5:4] != 2'b11
      |=> DATA_RDATA == 8'h00;
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank 1 hole not zero");
  property p_bank_wr;
    CE && DATA_WR && DATA_ADDR == 7'h03 |=> BANK_SEL == wd_q[5];
  endproperty
  a_bank_wr: assert property (p_bank_wr)
    else $error("bank not written");
  property p_ro;
    STATUS_VALUE[4:3] == 2'b11;
  endproperty
  a_ro: assert property (p_ro)
    else $error("status flags changed");
  property p_latch;
    CE && DATA_WR && DATA_ADDR == 7'h0A |=> PROGRAM_COUNTER_HIGH_LATCH_VALUE == wd_q[4:0];
  endproperty
  a_latch: assert property (p_latch)
    else $error("latch not written");
  c_irq: cover property (CE && PC_IRQ);
  c_bank: cover property (CE && DATA_WR && DATA_ADDR == 7'h03 ##1 BANK_SEL);
  c_hole: cover property (CE && DATA_RD && DATA_ADDR[6:5] == 2'b01);
endmodule

// >>> verification/mmbd_core_model.sv
// Core-side model: drives fetch control and the direct data port.
// Assumes one clock; signals change only right after a rising edge.
`timescale 1ns/1ps
module mmbd_core_model (
  input wire logic  CLK,
  input wire logic [7:0] DATA_RDATA,
  output logic      CE,
  output logic      PC_STEP,
  output logic      PC_IRQ,
  output logic      PC_LOAD,
  output logic [12:0] PC_LOAD_ADDR,
  output logic [6:0] DATA_ADDR,
  output logic [7:0] DATA_WDATA,
  output logic      DATA_WR,
  output logic      DATA_RD
);
  initial begin
    CE = 1'b1;
    {PC_STEP, PC_IRQ, PC_LOAD, DATA_WR, DATA_RD} = 5'h00;
    PC_LOAD_ADDR = 13'h0000;
    DATA_ADDR = 7'h00;
    DATA_WDATA = 8'h00;
  end
  // ==========================================================
  // Transfers
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge CLK);
    DATA_WR <= 1'b1;
    DATA_ADDR <= a;
    DATA_WDATA <= d;
    @(posedge CLK);
    DATA_WR <= 1'b0;
    // Released data shows garbage, not the last value
    DATA_WDATA <= ~d;
    #1;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge CLK);
    DATA_RD <= 1'b1;
    DATA_ADDR <= a;
    @(posedge CLK);
    DATA_RD <= 1'b0;
    #1;
    d = DATA_RDATA;
  endtask
  task automatic pc(input logic [2:0] ils, input logic [12:0] a);
    @(posedge CLK);
    {PC_IRQ, PC_LOAD, PC_STEP} <= ils;
    PC_LOAD_ADDR <= a;
    @(posedge CLK);
    {PC_IRQ, PC_LOAD, PC_STEP} <= 3'h0;
    PC_LOAD_ADDR <= ~a;
    #1;
  endtask
  // Reads status, then holds CE low for n edges with a write and a
  // step pending; neither may be taken while the block is frozen
  task automatic freeze(input int n);
    @(posedge CLK);
    DATA_RD <= 1'b1;
    DATA_ADDR <= 7'h03;
    @(posedge CLK);
    DATA_RD <= 1'b0;
    CE <= 1'b0;
    PC_STEP <= 1'b1;
    DATA_WR <= 1'b1;
    DATA_ADDR <= 7'h0B;
    DATA_WDATA <= 8'hFF;
    repeat (n) @(posedge CLK);
    CE <= 1'b1;
    PC_STEP <= 1'b0;
    DATA_WR <= 1'b0;
    #1;
  endtask
endmodule

// >>> verification/mmbd_top_bench.sv
// Self-checking bench for the memory map and bank decoder.
// Assumes mmbd_pkg, mmbd_top and the core model are compiled first.
`timescale 1ns/1ps
module mmbd_top_bench;
  logic        CLK, RESET_N, CE, PC_STEP, PC_IRQ, PC_LOAD;
  logic        DATA_WR, DATA_RD, BANK_SEL;
  logic [12:0] PC_LOAD_ADDR, PC_VALUE;
  logic [9:0]  PROG_ADDR;
  logic [6:0]  DATA_ADDR;
  logic [7:0]  DATA_WDATA, DATA_RDATA, STATUS_VALUE, INTERRUPT_CONTROL_VALUE;
  logic [4:0]  PROGRAM_COUNTER_HIGH_LATCH_VALUE;
  int          fail_count;
  int          checked;
  mmbd_top mmbd_top_i (.CLK(CLK), .RESET_N(RESET_N), .CE(CE),
    .PC_STEP(PC_STEP), .PC_IRQ(PC_IRQ), .PC_LOAD(PC_LOAD),
    .PC_LOAD_ADDR(PC_LOAD_ADDR), .PC_VALUE(PC_VALUE),
    .PROG_ADDR(PROG_ADDR), .DATA_ADDR(DATA_ADDR),
    .DATA_WDATA(DATA_WDATA), .DATA_WR(DATA_WR), .DATA_RD(DATA_RD),
    .DATA_RDATA(DATA_RDATA), .BANK_SEL(BANK_SEL),
    .STATUS_VALUE(STATUS_VALUE), .INTERRUPT_CONTROL_VALUE(INTERRUPT_CONTROL_VALUE),
    .PROGRAM_COUNTER_HIGH_LATCH_VALUE(PROGRAM_COUNTER_HIGH_LATCH_VALUE));
  mmbd_core_model mmbd_core_model_i (.CLK(CLK), .DATA_RDATA(DATA_RDATA),
    .CE(CE), .PC_STEP(PC_STEP), .PC_IRQ(PC_IRQ), .PC_LOAD(PC_LOAD),
    .PC_LOAD_ADDR(PC_LOAD_ADDR), .DATA_ADDR(DATA_ADDR),
    .DATA_WDATA(DATA_WDATA), .DATA_WR(DATA_WR), .DATA_RD(DATA_RD));
  always #2 CLK = ~CLK;
  // ==========================================================
  // Helpers
  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic w(input logic [6:0] a, input logic [7:0] d);
    mmbd_core_model_i.wr(a, d);
  endtask
  task automatic r(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    mmbd_core_model_i.rd(a, d);
    chk(d, e);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_prog;
    chk(PC_VALUE, 13'h0000);
    chk(STATUS_VALUE, 8'h18);
    mmbd_core_model_i.pc(3'h2, 13'h1FFF);
    chk(PROG_ADDR, 10'h3FF);
    mmbd_core_model_i.pc(3'h1, 13'h0000);
    chk(PC_VALUE, 13'h0000);
    mmbd_core_model_i.pc(3'h2, 13'h0405);
    chk(PROG_ADDR, 10'h005);
    mmbd_core_model_i.pc(3'h7, 13'h0123);
    chk(PC_VALUE, 13'h0004);
  endtask
  task automatic t_gpr;
    r(7'h04, 8'h00);
    for (logic [7:0] i = 8'h40; i < 8'h80; i++)
      w(i[6:0], i ^ 8'hA5);
    for (logic [7:0] i = 8'h40; i < 8'h80; i++)
      r(i[6:0], i ^ 8'hA5);
    w(7'h30, 8'h5A);
    r(7'h30, 8'h00);
    r(7'h01, 8'h00);
  endtask
  task automatic t_bank;
    w(7'h03, 8'h20);
    chk(BANK_SEL, 13'h0001);
    r(7'h72, 8'h72 ^ 8'hA5);
    w(7'h75, 8'h3C);
    r(7'h40, 8'h00);
    w(7'h0A, 8'h03);
    w(7'h03, 8'h07);
    chk(STATUS_VALUE, 8'h1F);
    r(7'h75, 8'h3C);
    r(7'h0A, 8'h03);
    r(7'h40, 8'h40 ^ 8'hA5);
    w(7'h02, 8'h21);
    chk(PC_VALUE, 13'h0321);
  endtask
  task automatic t_ind;
    w(7'h04, 8'h45);
    r(7'h00, 8'h45 ^ 8'hA5);
    w(7'h00, 8'h99);
    r(7'h45, 8'h99);
    w(7'h04, 8'hF3);
    r(7'h00, 8'h73 ^ 8'hA5);
    w(7'h04, 8'h00);
    r(7'h00, 8'h00);
  endtask
  task automatic t_core;
    w(7'h0B, 8'hC3);
    chk(INTERRUPT_CONTROL_VALUE, 13'h00C3);
    r(7'h0B, 8'hC3);
    r(7'h02, 8'h21);
    w(7'h04, 8'h7F);
    r(7'h00, 8'h7F ^ 8'hA5);
    w(7'h03, 8'h20);
    r(7'h03, 8'h38);
    r(7'h0B, 8'hC3);
    r(7'h04, 8'h7F);
    w(7'h0A, 8'hFF);
    r(7'h0A, 8'h1F);
    w(7'h03, 8'h00);
    chk(STATUS_VALUE, 13'h0018);
  endtask
  task automatic t_freeze;
    mmbd_core_model_i.freeze(4);
    chk(PC_VALUE, 13'h0321);
    chk(INTERRUPT_CONTROL_VALUE, 13'h00C3);
    chk(DATA_RDATA, 13'h0018);
  endtask
  task automatic t_reset;
    @(posedge CLK);
    RESET_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RESET_N <= 1'b1;
    #1;
    chk(PC_VALUE, 13'h0000);
    chk(INTERRUPT_CONTROL_VALUE, 13'h0000);
    chk(PROGRAM_COUNTER_HIGH_LATCH_VALUE, 13'h0000);
    r(7'h04, 8'h00);
  endtask
  // ==========================================================
  // Main sequence and hang guard
  initial begin
    CLK = 1'b0;
    RESET_N = 1'b0;
    fail_count = 0;
    checked = 0;
    repeat (8) @(posedge CLK);
    RESET_N <= 1'b1;
    #1;
    t_prog;
    t_gpr;
    t_bank;
    t_ind;
    t_core;
    t_freeze;
    t_reset;
    print_verdict;
  end
  initial begin
    repeat (5000) @(posedge CLK);
    fail_count++;
    $display("wrong value at %0t: run did not finish", $time);
    print_verdict;
  end
endmodule
bind mmbd_top mmbd_top_checker #(.PC_W(PC_W), .IMPL_W(IMPL_W)) chk_i (
  .CLK(CLK), .RESET_N(RESET_N), .CE(CE), .PC_STEP(PC_STEP),
  .PC_IRQ(PC_IRQ), .PC_LOAD(PC_LOAD), .PC_LOAD_ADDR(PC_LOAD_ADDR),
  .PC_VALUE(PC_VALUE), .PROG_ADDR(PROG_ADDR), .DATA_ADDR(DATA_ADDR),
  .DATA_WDATA(DATA_WDATA), .DATA_WR(DATA_WR), .DATA_RD(DATA_RD),
  .DATA_RDATA(DATA_RDATA), .BANK_SEL(BANK_SEL),
  .STATUS_VALUE(STATUS_VALUE), .PROGRAM_COUNTER_HIGH_LATCH_VALUE(PROGRAM_COUNTER_HIGH_LATCH_VALUE));
